// file: rtl/iox_pkg.sv
// Constants and types shared by the I/O expander serial port
package iox_pkg;

   // Register select codes carried in the low bits of the command pointer
   localparam logic [1:0] REG_INPUT = 2'h0;
   localparam logic [1:0] REG_OUTPUT = 2'h1;
   localparam logic [1:0] REG_POLARITY = 2'h2;
   localparam logic [1:0] REG_DIRECTION = 2'h3;

   // Register reset values
   localparam logic [7:0] OUT_RST = 8'hFF;
   localparam logic [7:0] POL_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'hFF;
   localparam logic [7:0] PTR_RST = 8'h00;

   // Fixed upper part of the seven-bit bus address
   localparam logic [3:0] ADDR_PREFIX = 4'h4;

   // Value of the direction flag that requests a read
   localparam logic RW_READ = 1'b1;

   // Bit counts within a byte
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;

   // Layout of the synchronised input vector
   localparam int SYNC_W = 13;
   localparam int SCL_POS = 0;
   localparam int SDA_POS = 1;
   localparam int PIN_LSB = 2;
   localparam int STRAP_LSB = 10;

   // Bus lines idle high, pins and straps low
   localparam logic [12:0] SYNC_RST = 13'h0003;

   // Serial protocol states
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_RECV = 7'h02,
      ST_ACK = 7'h04,
      ST_SEND = 7'h08,
      ST_MACK = 7'h10,
      ST_LOAD = 7'h20,
      ST_WAIT = 7'h40
   } iox_state_t;

endpackage

// file: rtl/iox_top.sv
// Serial target port and register file of the eight-bit I/O expander
`timescale 1ns/10ps
`default_nettype none

module iox_top
   import iox_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial bus, data line is open drain
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Address straps
   input wire logic addr_strap_bit0,
   input wire logic addr_strap_bit1,
   input wire logic addr_strap_bit2,
   // Port pins
   input wire logic [7:0] port_pin_in,
   output logic [7:0] port_pin_out,
   output logic [7:0] port_pin_oe,
   output logic [7:0] high_side_driver,
   output logic [7:0] low_side_driver,
   // Command pointer view
   output logic [7:0] cmd_ptr
);

   logic [SYNC_W-1:0] in_raw;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic [SYNC_W-1:0] sync3_q;
   logic [SYNC_W-1:0] filt_q;
   logic [SYNC_W-1:0] filt_d;
   logic [SYNC_W-1:0] agree;
   logic scl_p_q;
   logic sda_p_q;
   logic scl_f;
   logic sda_f;
   logic [7:0] pins;
   logic [2:0] strap;
   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic scl_fall;

   iox_state_t st_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] sr_q;
   logic addr_ph_q;
   logic cmd_ph_q;
   logic rw_q;
   logic sda_oe_q;
   logic sda_out_q;

   logic [7:0] ptr_q;
   logic [7:0] out_q;
   logic [7:0] pol_q;
   logic [7:0] dir_q;
   logic [7:0] pin_out_q;
   logic [7:0] pin_oe_q;
   logic [7:0] hi_drv_q;
   logic [7:0] lo_drv_q;

   logic byte_done;
   logic own_match;
   logic cmd_wr;
   logic data_wr;
   logic [7:0] rd_byte;

   assign in_raw = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, port_pin_in, sda_in, scl_in};
   assign agree = ~(sync2_q ^ sync3_q);
   assign filt_d = (agree & sync3_q) | (~agree & filt_q);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
         sync3_q <= SYNC_RST;
         filt_q <= SYNC_RST;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         sync1_q <= in_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         filt_q <= filt_d;
         scl_p_q <= filt_q[SCL_POS];
         sda_p_q <= filt_q[SDA_POS];
      end
   end

   assign scl_f = filt_q[SCL_POS];
   assign sda_f = filt_q[SDA_POS];
   assign pins = filt_q[PIN_LSB +: 8];
   assign strap = filt_q[STRAP_LSB +: 3];

   // data edges while clock high are control events
   assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
   assign stop_det = scl_f & scl_p_q & ~sda_p_q & sda_f;
   assign scl_rise = scl_f & ~scl_p_q;
   assign scl_fall = ~scl_f & scl_p_q;

   // a byte ends on the clock fall after its eighth bit
   assign byte_done = (st_q == ST_RECV) && scl_fall && (bit_cnt_q == BYTE_BITS);
   assign own_match = (sr_q[7:1] == {ADDR_PREFIX, strap});
   // first write byte is the command
   assign cmd_wr = byte_done && !addr_ph_q && cmd_ph_q;
   assign data_wr = byte_done && !addr_ph_q && !cmd_ph_q;

   always_comb begin
      case (ptr_q[1:0])
         REG_INPUT: rd_byte = pins ^ pol_q;
         REG_OUTPUT: rd_byte = out_q;
         REG_POLARITY: rd_byte = pol_q;
         REG_DIRECTION: rd_byte = dir_q;
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         sr_q <= 8'h00;
         addr_ph_q <= 1'b0;
         cmd_ph_q <= 1'b0;
         rw_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (stop_det) begin
         st_q <= ST_IDLE;
         sda_oe_q <= 1'b0;
      end else if (start_det) begin
         st_q <= ST_RECV;
         bit_cnt_q <= 4'h0;
         addr_ph_q <= 1'b1;
         cmd_ph_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         case (st_q)
            ST_RECV: begin
               // shift in most significant bit first
               if (scl_rise && bit_cnt_q != BYTE_BITS) begin
                  sr_q <= {sr_q[6:0], sda_f};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
               if (byte_done) begin
                  if (addr_ph_q) begin
                     if (own_match) begin
                        // direction from the last address bit
                        rw_q <= sr_q[0];
                        cmd_ph_q <= (sr_q[0] != RW_READ);
                        addr_ph_q <= 1'b0;
                        st_q <= ST_ACK;
                        sda_oe_q <= 1'b1;
                     end else begin
                        st_q <= ST_WAIT;
                     end
                  end else begin
                     cmd_ph_q <= 1'b0;
                     st_q <= ST_ACK;
                     sda_oe_q <= 1'b1;
                  end
               end
            end
            ST_ACK: begin
               // hold low through the acknowledge high phase
               if (scl_fall) begin
                  bit_cnt_q <= 4'h0;
                  if (rw_q == RW_READ) begin
                     // read data from the stored pointer
                     st_q <= ST_SEND;
                     sr_q <= rd_byte;
                     sda_oe_q <= ~rd_byte[7];
                  end else begin
                     st_q <= ST_RECV;
                     sda_oe_q <= 1'b0;
                  end
               end
            end
            ST_SEND: begin
               if (scl_fall) begin
                  if (bit_cnt_q == LAST_TX_BIT) begin
                     st_q <= ST_MACK;
                     sda_oe_q <= 1'b0;
                  end else begin
                     sr_q <= {sr_q[6:0], 1'b0};
                     sda_oe_q <= ~sr_q[6];
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               // low means another byte is wanted
               // high ends the read with data released
               if (scl_rise) begin
                  st_q <= sda_f ? ST_WAIT : ST_LOAD;
               end
            end
            ST_LOAD: begin
               if (scl_fall) begin
                  st_q <= ST_SEND;
                  bit_cnt_q <= 4'h0;
                  sr_q <= rd_byte;
                  sda_oe_q <= ~rd_byte[7];
               end
            end
            ST_IDLE, ST_WAIT: begin
               sda_oe_q <= 1'b0;
            end
            default: begin
               st_q <= ST_IDLE;
               sda_oe_q <= 1'b0;
            end
         endcase
      end
   end

   // reset defaults leave all pins as inputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ptr_q <= PTR_RST;
         out_q <= OUT_RST;
         pol_q <= POL_RST;
         dir_q <= DIR_RST;
      end else if (cmd_wr) begin
         // the whole byte is kept and shown on cmd_ptr
         ptr_q <= sr_q;
      end else if (data_wr) begin
         case (ptr_q[1:0])
            REG_OUTPUT: out_q <= sr_q;
            REG_POLARITY: pol_q <= sr_q;
            REG_DIRECTION: dir_q <= sr_q;
            default: out_q <= out_q;
         endcase
      end
   end

   // Pin drivers registered so every output leaves a flip-flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_out_q <= OUT_RST;
         pin_oe_q <= 8'h00;
         hi_drv_q <= 8'h00;
         lo_drv_q <= 8'h00;
         sda_out_q <= 1'b0;
      end else begin
         pin_out_q <= out_q;
         // direction bit one disables the driver
         pin_oe_q <= ~dir_q;
         hi_drv_q <= ~dir_q & out_q;
         lo_drv_q <= ~dir_q & ~out_q;
         sda_out_q <= 1'b0;
      end
   end

   assign sda_out = sda_out_q;
   assign sda_oe = sda_oe_q;
   assign port_pin_out = pin_out_q;
   assign port_pin_oe = pin_oe_q;
   assign high_side_driver = hi_drv_q;
   assign low_side_driver = lo_drv_q;
   assign cmd_ptr = ptr_q;

   property p_input_hiz;
      @(posedge clk) disable iff (rst)
      1'b1 |=> ((high_side_driver | low_side_driver | port_pin_oe) & $past(dir_q)) == 8'h00;
   endproperty
   a_input_hiz: assert property (p_input_hiz) else $error("input pin has a driver on");

   property p_output_level;
      @(posedge clk) disable iff (rst)
      1'b1 |=> high_side_driver == ($past(out_q) & port_pin_oe) && low_side_driver == (~$past(out_q) & port_pin_oe);
   endproperty
   a_output_level: assert property (p_output_level) else $error("output level differs from value");

   property p_reset_inputs;
      @(posedge clk) disable iff (rst)
      $fell(rst) |-> dir_q == DIR_RST && out_q == OUT_RST && pol_q == POL_RST && port_pin_oe == 8'h00;
   endproperty
   a_reset_inputs: assert property (p_reset_inputs) else $error("registers not at defaults after reset");

   property p_start;
      @(posedge clk) disable iff (rst)
      start_det && !stop_det |=> st_q == ST_RECV && bit_cnt_q == 4'h0 && addr_ph_q && !sda_oe;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_stop;
      @(posedge clk) disable iff (rst)
      stop_det |=> st_q == ST_IDLE ##1 !sda_oe;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not return to idle");

   property p_addr_ack;
      @(posedge clk) disable iff (rst)
      byte_done && addr_ph_q && own_match && !start_det && !stop_det |=> sda_oe throughout (!scl_fall [*2]);
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

   property p_foreign_addr;
      @(posedge clk) disable iff (rst)
      byte_done && addr_ph_q && !own_match && !start_det && !stop_det |=> st_q == ST_WAIT && !sda_oe;
   endproperty
   a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address acknowledged");

   property p_write_ack;
      @(posedge clk) disable iff (rst)
      byte_done && !addr_ph_q && !start_det && !stop_det |=> st_q == ST_ACK && sda_oe;
   endproperty
   a_write_ack: assert property (p_write_ack) else $error("received byte not acknowledged");

   property p_input_no_write;
      @(posedge clk) disable iff (rst)
      data_wr && ptr_q[1:0] == REG_INPUT |=> $stable(out_q) && $stable(pol_q) && $stable(dir_q);
   endproperty
   a_input_no_write: assert property (p_input_no_write) else $error("write to input register had effect");

   property p_nack_release;
      @(posedge clk) disable iff (rst)
      st_q == ST_MACK && scl_rise && sda_f && !stop_det && !start_det |=> st_q == ST_WAIT ##1 !sda_oe;
   endproperty
   a_nack_release: assert property (p_nack_release) else $error("data not released after nack");

   property p_ptr_hold;
      @(posedge clk) disable iff (rst)
      !cmd_wr |=> $stable(ptr_q);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed without command byte");

endmodule

`default_nettype wire

// file: tb/iox_bus_master_model.sv
// Behavioural two-wire bus controller facing the expander's serial port
`timescale 1ns/10ps
`default_nettype none
module iox_bus_master_model (
   // Clock
   input wire logic clk,
   // Serial bus, data line pulled up outside
   input wire logic sda,
   output var logic scl,
   output var logic sda_pull
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // Third of a bit period (the clock high time), well above the port's filter delay
   task automatic phase();
      repeat (8) @(posedge clk);
      #1;
   endtask
   task automatic start();
      sda_pull = 1'b0;
      phase();
      scl = 1'b1;
      phase();
      sda_pull = 1'b1;
      phase();
      scl = 1'b0;
   endtask
   task automatic stop();
      sda_pull = 1'b1;
      phase();
      scl = 1'b1;
      phase();
      sda_pull = 1'b0;
      phase();
   endtask
   // one bit per pulse, data held across the high phase
   task automatic pulse(output logic seen);
      phase();
      scl = 1'b1;
      phase();
      seen = sda;
      scl = 1'b0;
      phase();
   endtask
   task automatic send(input logic [7:0] b, output logic ack_n);
      logic unused;
      for (int i = 7; i >= 0; i--) begin
         sda_pull = ~b[i];
         pulse(unused);
      end
      sda_pull = 1'b0;
      pulse(ack_n);
   endtask
   // acknowledge all but the last byte
   task automatic receive(input logic last, output logic [7:0] b, output logic slot);
      logic v;
      sda_pull = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         pulse(v);
         b[i] = v;
      end
      sda_pull = ~last;
      pulse(slot);
   endtask
endmodule
`default_nettype wire

// file: tb/iox_top_test.sv
// Self-checking bench for the I/O expander serial port
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin miscompares++; \
   $display("mismatch at %0t: got %h expected %h", $time, (act), (exp)); end end
module iox_top_test;
   import iox_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] strap = 3'h0;
   logic [7:0] port_pin_in = 8'h00;
   logic scl, sda_pull, sda_out, sda_oe;
   logic [7:0] port_pin_out, port_pin_oe, high_side_driver, low_side_driver, cmd_ptr;
   wire logic sda;
   int miscompares = 0;
   int checks_done = 0;
   int out_m = 'hFF;
   int pol_m = 'h00;
   int dir_m = 'hFF;
   int ptr_m = 'h00;
   int rd_q[$];
   always #12.5 clk = ~clk;
   // Open-drain wire with pull-up
   assign sda = ~(sda_pull | sda_oe);
   iox_top u_dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
      .port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
      .high_side_driver(high_side_driver), .low_side_driver(low_side_driver), .cmd_ptr(cmd_ptr));
   iox_bus_master_model u_mst (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
   function automatic logic [7:0] exp_rd();
      case (ptr_m & 3)
         0: return port_pin_in ^ 8'(pol_m);
         1: return 8'(out_m);
         2: return 8'(pol_m);
         default: return 8'(dir_m);
      endcase
   endfunction
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr_cycle(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
      logic a;
      u_mst.start();
      u_mst.send({ADDR_PREFIX, strap, 1'b0}, a);
      `CHK(a, 1'b0)
      u_mst.send(cmd, a);
      `CHK(a, 1'b0)
      `CHK(cmd_ptr, cmd)
      ptr_m = cmd;
      u_mst.send(d0, a);
      `CHK(a, 1'b0)
      u_mst.send(d1, a);
      `CHK(a, 1'b0)
      u_mst.stop();
      case (ptr_m & 3)
         1: out_m = d1;
         2: pol_m = d1;
         3: dir_m = d1;
         default: ;
      endcase
   endtask
   task automatic rd_cycle(input logic set_ptr, input logic [7:0] cmd);
      logic a;
      logic [7:0] b;
      u_mst.start();
      if (set_ptr) begin
         u_mst.send({ADDR_PREFIX, strap, 1'b0}, a);
         u_mst.send(cmd, a);
         `CHK(a, 1'b0)
         ptr_m = cmd;
         u_mst.start();
      end
      u_mst.send({ADDR_PREFIX, strap, RW_READ}, a);
      `CHK(a, 1'b0)
      rd_q.push_back(int'(exp_rd()));
      rd_q.push_back(int'(exp_rd()));
      u_mst.receive(1'b0, b, a);
      `CHK(b, 8'(rd_q.pop_front()))
      u_mst.receive(1'b1, b, a);
      `CHK(b, 8'(rd_q.pop_front()))
      `CHK(a, 1'b1)
      u_mst.stop();
   endtask
   task automatic pins_chk();
      repeat (3) @(posedge clk);
      #1;
      `CHK(port_pin_oe, ~8'(dir_m))
      `CHK(high_side_driver, ~8'(dir_m) & 8'(out_m))
      `CHK(low_side_driver, ~8'(dir_m) & ~8'(out_m))
      `CHK(port_pin_out, 8'(out_m))
      `CHK(sda_out, 1'b0)
   endtask
   // Reset held three cycles, defaults checked during and after it
   task automatic rst_pulse();
      rst = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      `CHK(sda_oe, 1'b0)
      `CHK(cmd_ptr, PTR_RST)
      `CHK(port_pin_oe, 8'h00)
      rst = 1'b0;
      out_m = int'(OUT_RST);
      pol_m = int'(POL_RST);
      dir_m = int'(DIR_RST);
      ptr_m = int'(PTR_RST);
      pins_chk();
   endtask
   initial begin
      logic a;
      void'($urandom(32'hEA77));
      rst_pulse();
      for (int r = 1; r < 4; r++)
         rd_cycle(1'b1, 8'(r));
      // Foreign addresses are ignored
      for (int k = 0; k < 2; k++) begin
         u_mst.start();
         u_mst.send({k[0] ? 4'h5 : ADDR_PREFIX, ~strap, 1'b0}, a);
         `CHK(a, 1'b1)
         u_mst.send(8'h02, a);
         `CHK(a, 1'b1)
         u_mst.stop();
         `CHK(cmd_ptr, 8'(ptr_m))
      end
      for (int n = 0; n < 12; n++) begin
         strap = 3'($urandom());
         port_pin_in = 8'($urandom());
         wr_cycle({6'($urandom()), 2'(n)}, 8'($urandom()), 8'($urandom()));
         pins_chk();
         rd_cycle(n[2], {6'($urandom()), 2'(n + 1)});
         rd_cycle(1'b0, 8'h00);
      end
      // Mid-run reset restores every register default
      rst_pulse();
      for (int r = 0; r < 4; r++)
         rd_cycle(r != 0, 8'(r));
      finish_test();
   end
   // Watchdog for a stalled run
   initial begin
      repeat (95000) @(posedge clk);
      miscompares++;
      finish_test();
   end
endmodule
`default_nettype wire
